/* File: design/apm_pkg.sv */
// constants and carriers for the codec power-state register block
// Notes on behaviour
// - one write changes all audio power-down bits together
// - amp output follows external amp power-down bit
// - wake-on-ring keeps modem gpio section powered
// - secondary codec uses own clock when down
// - modem link-off lives in register 56h bit 12
// - link plus clock power-down stops bit clock
package apm_pkg;

    // register indices
    localparam logic [6:0] AUD_PD_ADDR = 7'h26;
    localparam logic [6:0] MDM_PD_ADDR = 7'h3e;
    localparam logic [6:0] MDM_LINK_ADDR = 7'h56;

    // field positions
    localparam int AUD_RDY_LSB = 0;
    localparam int AUD_RDY_W = 4;
    localparam int AUD_PD_LSB = 8;
    localparam int AUD_PD_W = 6;
    localparam int AUD_AMP_PD_POS = 15;
    localparam int MDM_WOR_POS = 0;
    localparam int MDM_PD_LSB = 8;
    localparam int MDM_PD_W = 4;
    localparam int MDM_LINK_OFF_POS = 12;

    // reset values: everything powered (D0)
    localparam logic [5:0] AUD_PD_RST = 6'h00;
    localparam logic [3:0] MDM_PD_RST = 4'h0;
    localparam logic [3:0] AUD_RDY_RST = 4'hf;

    // section settle time before ready is reported again
    localparam int SETTLE_NS = 100;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SETTLE_CYC =
        (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SETTLE_W = 8;

    // audio power-down bits, msb = clock, lsb = adc
    typedef struct packed {
        logic clk;
        logic link;
        logic vref;
        logic mixer;
        logic dac;
        logic adc;
    } apm_aud_pd_s;

    // modem power-down bits, msb = gpio, lsb = dac1
    typedef struct packed {
        logic gpio;
        logic vref;
        logic adc1;
        logic dac1;
    } apm_mdm_pd_s;

    // register request as delivered by the link slot decoder
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [15:0] wdata;
    } apm_req_s;

endpackage

/* File: design/apm_power_map.sv */
// codec power-down registers, section controls and link clock gating
`timescale 1ns/1ps
module apm_power_map #(
    parameter int SETTLE_CYCLES = apm_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic warm_rst_i,
    // register access from the link slot decoder
    input wire apm_pkg::apm_req_s req_i,
    output logic [15:0] rdata_o,
    output logic rvalid_o,
    // section power-down controls
    output apm_pkg::apm_aud_pd_s aud_pd_o,
    output apm_pkg::apm_mdm_pd_s mdm_pd_o,
    // pins and clocking
    input wire logic secondary_i,
    output logic amp_enable_o,
    output logic sdata_in_low_o,
    output logic bit_clk_en_o,
    output logic ext_clk_sel_o
);

    // address match, used for reads and writes alike
    function automatic logic hit(input logic [6:0] a, input logic [6:0] t);
        hit = (a == t);
    endfunction

    logic wr_aud;
    logic wr_mdm;
    logic wr_link;
    assign wr_aud = req_i.wr && hit(req_i.addr, apm_pkg::AUD_PD_ADDR);
    assign wr_mdm = req_i.wr && hit(req_i.addr, apm_pkg::MDM_PD_ADDR);
    assign wr_link = req_i.wr && hit(req_i.addr, apm_pkg::MDM_LINK_ADDR);

    // strap synchroniser; the first stage feeds only the second
    logic sec_meta_ff;
    logic sec_sync_ff;
    logic sec_strap_ff;
    logic strap_done_ff;
    logic [1:0] strap_cnt_ff;
    logic nxt_sec_strap;
    logic nxt_strap_done;
    logic [1:0] nxt_strap_cnt;

    // strap is caught once the sync stages hold the pin, then held;
    // capturing earlier would latch the reset value of the stages
    always_comb begin
        nxt_sec_strap = sec_strap_ff;
        nxt_strap_done = strap_done_ff;
        nxt_strap_cnt = strap_cnt_ff;
        if (!strap_done_ff) begin
            if (strap_cnt_ff == 2'h2) begin
                nxt_sec_strap = sec_sync_ff;
                nxt_strap_done = 1'b1;
            end else begin
                nxt_strap_cnt = strap_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sec_meta_ff <= 1'b0;
            sec_sync_ff <= 1'b0;
            sec_strap_ff <= 1'b0;
            strap_done_ff <= 1'b0;
            strap_cnt_ff <= 2'h0;
        end else begin
            sec_meta_ff <= secondary_i;
            sec_sync_ff <= sec_meta_ff;
            sec_strap_ff <= nxt_sec_strap;
            strap_done_ff <= nxt_strap_done;
            strap_cnt_ff <= nxt_strap_cnt;
        end
    end

    // stored register contents
    apm_pkg::apm_aud_pd_s aud_pd_ff;
    apm_pkg::apm_aud_pd_s nxt_aud_pd;
    logic amp_pd_ff;
    logic nxt_amp_pd;
    apm_pkg::apm_mdm_pd_s mdm_pd_ff;
    apm_pkg::apm_mdm_pd_s nxt_mdm_pd;
    logic wor_ff;
    logic nxt_wor;
    logic link_off_ff;
    logic nxt_link_off;

    // whole fields load in one cycle, no bit ordering imposed
    always_comb begin
        nxt_aud_pd = aud_pd_ff;
        nxt_amp_pd = amp_pd_ff;
        nxt_mdm_pd = mdm_pd_ff;
        nxt_wor = wor_ff;
        nxt_link_off = link_off_ff;
        if (warm_rst_i) begin
            // warm reset puts every section back in D0
            nxt_aud_pd = apm_pkg::AUD_PD_RST;
            nxt_amp_pd = 1'b0;
            nxt_mdm_pd = apm_pkg::MDM_PD_RST;
            nxt_link_off = 1'b0;
        end else begin
            if (wr_aud) begin
                nxt_aud_pd = req_i.wdata[apm_pkg::AUD_PD_LSB +: 6];
                nxt_amp_pd = req_i.wdata[apm_pkg::AUD_AMP_PD_POS];
            end
            if (wr_mdm) begin
                nxt_mdm_pd = req_i.wdata[apm_pkg::MDM_PD_LSB +: 4];
                nxt_wor = req_i.wdata[apm_pkg::MDM_WOR_POS];
            end
            if (wr_link) begin
                nxt_link_off = req_i.wdata[apm_pkg::MDM_LINK_OFF_POS];
            end
        end
    end

    // derived pin levels, registered together with the fields
    apm_pkg::apm_mdm_pd_s nxt_mdm_out;
    logic nxt_clk_en;
    logic nxt_ext_clk;
    always_comb begin
        nxt_mdm_out = nxt_mdm_pd;
        // ring detect needs the gpio section while wake is armed
        nxt_mdm_out.gpio = nxt_mdm_pd.gpio && !nxt_wor;
        nxt_clk_en = !(nxt_aud_pd.link && nxt_aud_pd.clk);
        // the secondary keeps its state machines on its own clock
        nxt_ext_clk = nxt_sec_strap && (|nxt_mdm_out);
    end

    logic [apm_pkg::AUD_RDY_W-1:0] rdy_ff;
    logic [apm_pkg::AUD_RDY_W-1:0] nxt_rdy;
    logic [apm_pkg::SETTLE_W-1:0] settle_ff;
    logic [apm_pkg::SETTLE_W-1:0] nxt_settle;
    logic [apm_pkg::AUD_RDY_W-1:0] pd_low;
    logic [apm_pkg::AUD_RDY_W-1:0] reenabled;

    // ready drops at once on power-down, returns after settling;
    // one shared counter, so a later re-enable restarts it for all
    always_comb begin
        pd_low = nxt_aud_pd[apm_pkg::AUD_RDY_W-1:0];
        reenabled = aud_pd_ff[apm_pkg::AUD_RDY_W-1:0] & ~pd_low;
        nxt_settle = settle_ff;
        if (|reenabled) begin
            nxt_settle = SETTLE_CYCLES[apm_pkg::SETTLE_W-1:0];
        end else if (settle_ff != '0) begin
            nxt_settle = settle_ff - 1'b1;
        end
        if (nxt_settle == '0) begin
            nxt_rdy = ~pd_low;
        end else begin
            nxt_rdy = ~pd_low & rdy_ff;
        end
    end

    // read mux; unmapped indices read zero
    logic [15:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 16'h0000;
        if (hit(req_i.addr, apm_pkg::AUD_PD_ADDR)) begin
            nxt_rdata[apm_pkg::AUD_RDY_LSB +: 4] = rdy_ff;
            nxt_rdata[apm_pkg::AUD_PD_LSB +: 6] = aud_pd_ff;
            nxt_rdata[apm_pkg::AUD_AMP_PD_POS] = amp_pd_ff;
        end else if (hit(req_i.addr, apm_pkg::MDM_PD_ADDR)) begin
            nxt_rdata[apm_pkg::MDM_PD_LSB +: 4] = mdm_pd_ff;
            nxt_rdata[apm_pkg::MDM_WOR_POS] = wor_ff;
        end else if (hit(req_i.addr, apm_pkg::MDM_LINK_ADDR)) begin
            nxt_rdata[apm_pkg::MDM_LINK_OFF_POS] = link_off_ff;
        end
        if (!req_i.rd) begin
            nxt_rdata = rdata_o;
        end
    end

    // all state registers apart from the strap synchroniser
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aud_pd_ff <= apm_pkg::AUD_PD_RST;
            amp_pd_ff <= 1'b0;
            mdm_pd_ff <= apm_pkg::MDM_PD_RST;
            wor_ff <= 1'b0;
            link_off_ff <= 1'b0;
            rdy_ff <= apm_pkg::AUD_RDY_RST;
            settle_ff <= '0;
            rdata_o <= 16'h0000;
            rvalid_o <= 1'b0;
            mdm_pd_o <= apm_pkg::MDM_PD_RST;
            amp_enable_o <= 1'b1;
            sdata_in_low_o <= 1'b0;
            bit_clk_en_o <= 1'b1;
            ext_clk_sel_o <= 1'b0;
        end else begin
            aud_pd_ff <= nxt_aud_pd;
            amp_pd_ff <= nxt_amp_pd;
            mdm_pd_ff <= nxt_mdm_pd;
            wor_ff <= nxt_wor;
            link_off_ff <= nxt_link_off;
            rdy_ff <= nxt_rdy;
            settle_ff <= nxt_settle;
            rdata_o <= nxt_rdata;
            rvalid_o <= req_i.rd;
            mdm_pd_o <= nxt_mdm_out;
            amp_enable_o <= !nxt_amp_pd;
            sdata_in_low_o <= nxt_link_off;
            bit_clk_en_o <= nxt_clk_en;
            ext_clk_sel_o <= nxt_ext_clk;
        end
    end

    assign aud_pd_o = aud_pd_ff;

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);

    sequence aud_write_s;
        wr_aud && !warm_rst_i;
    endsequence

    sequence mdm_only_write_s;
        wr_mdm && !warm_rst_i;
    endsequence

    aud_write_atomic_a: assert property (
        aud_write_s |=> aud_pd_o == $past(req_i.wdata[13:8]))
        else $error("audio power-down bits not applied together");

    amp_follow_a: assert property (
        aud_write_s |=> amp_enable_o == !$past(req_i.wdata[15]))
        else $error("amp output does not follow amp power-down bit");

    gpio_kept_a: assert property (
        wor_ff |-> !mdm_pd_o.gpio)
        else $error("gpio section powered down with ring wake armed");

    link_off_addr_a: assert property (
        mdm_only_write_s |=> $stable(sdata_in_low_o))
        else $error("modem power register moved the link-off control");

    link_off_set_a: assert property (
        wr_link && !warm_rst_i
        |=> sdata_in_low_o == $past(req_i.wdata[12]))
        else $error("link-off bit not taken from register 56h bit 12");

    clk_stop_a: assert property (
        bit_clk_en_o == !(aud_pd_o.link && aud_pd_o.clk))
        else $error("bit clock gating disagrees with link and clock bits");

    ext_clk_a: assert property (
        strap_done_ff && sec_strap_ff && (|mdm_pd_o) |-> ext_clk_sel_o)
        else $error("powered-down secondary not on its own clock");

    warm_d0_a: assert property (
        warm_rst_i |=> aud_pd_o == '0 && amp_enable_o && bit_clk_en_o)
        else $error("warm reset did not restore full power");

endmodule // apm_power_map

/* File: verification/apm_drv_model.sv */
// driver-side model that writes and reads the codec power registers
`timescale 1ns/1ps
module apm_drv_model (
    // clock
    input wire logic core_clk_i,
    // register port
    output apm_pkg::apm_req_s req_o,
    input wire logic [15:0] rdata_i,
    input wire logic rvalid_i
);
    // audio patterns D0..D3 lone codec, then D3 on a shared link
    function automatic logic [15:0] aud_d(input int i);
        case (i)
            0: aud_d = 16'h0000;
            1: aud_d = 16'h0300;
            2: aud_d = 16'h8700;
            3: aud_d = 16'hbf00;
            default: aud_d = 16'h8f00;
        endcase
    endfunction

    // modem patterns D0, D1/D2, D1/D2 with ring wake, full D3
    function automatic logic [15:0] mdm_d(input int i);
        case (i)
            0: mdm_d = 16'h0000;
            1: mdm_d = 16'h0300;
            2: mdm_d = 16'h0301;
            default: mdm_d = 16'h0f00;
        endcase
    endfunction

    // link-off level that goes with each modem pattern
    function automatic logic mdm_lk(input int i);
        mdm_lk = (i >= 2);
    endfunction

    initial req_o = '0;

    // one whole 16-bit unit per write; released lines show inverted data
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // answer is taken one cycle after the request edge
    task automatic rd(input logic [6:0] a, output logic [15:0] d,
        output logic v);
        @(posedge core_clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req_o.wdata};
        @(posedge core_clk_i);
        #1 req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: req_o.wdata};
        v = rvalid_i;
        d = rdata_i;
    endtask
endmodule // apm_drv_model

/* File: verification/testbench.sv */
// self-checking bench for the codec power-state register block
`timescale 1ns/1ps
module testbench;
    logic core_clk_i;
    logic rstn_i;
    logic warm_rst_i;
    logic secondary_i;
    apm_pkg::apm_req_s req;
    logic [15:0] rdata;
    logic rvalid;
    apm_pkg::apm_aud_pd_s aud_pd;
    apm_pkg::apm_mdm_pd_s mdm_pd;
    logic amp_en, sdin_low, bclk_en, ext_sel;
    logic [15:0] cur_a = '0;
    logic [15:0] cur_m = '0;
    logic cur_lk = 1'b0;
    logic cur_sec = 1'b0;
    int error_cnt = 0;
    int checks_done = 0;

    apm_power_map #(.SETTLE_CYCLES(2)) dut (.core_clk_i(core_clk_i),
        .rstn_i(rstn_i), .warm_rst_i(warm_rst_i), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .aud_pd_o(aud_pd),
        .mdm_pd_o(mdm_pd), .secondary_i(secondary_i),
        .amp_enable_o(amp_en), .sdata_in_low_o(sdin_low),
        .bit_clk_en_o(bclk_en), .ext_clk_sel_o(ext_sel));
    apm_drv_model drv (.core_clk_i(core_clk_i), .req_o(req),
        .rdata_i(rdata), .rvalid_i(rvalid));

    // 200 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // all pin-level outputs packed into one word for single compares
    function automatic logic [15:0] outs();
        return {2'h0, amp_en, bclk_en, sdin_low, ext_sel, mdm_pd, aud_pd};
    endfunction

    function automatic logic [15:0] exp_outs();
        return {2'h0, ~cur_a[15], ~(cur_a[12] & cur_a[13]), cur_lk,
            cur_sec & (|cur_m[11:8]), cur_m[11] & ~cur_m[0], cur_m[10:8],
            cur_a[13:8]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
        input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // cold reset; strap needs a few edges after release to be captured
    task automatic cold_rst(input logic sec);
        rstn_i = 1'b0;
        secondary_i = sec;
        repeat (10) @(posedge core_clk_i);
        #1 rstn_i = 1'b1;
        repeat (4) @(posedge core_clk_i);
        #1;
        cur_a = '0;
        cur_m = '0;
        cur_lk = 1'b0;
        cur_sec = sec;
    endtask

    task automatic t_reset();
        logic [15:0] d;
        logic v;
        chk(outs(), exp_outs(), "outputs after reset");
        drv.rd(7'h10, d, v);
        chk({15'h0, v}, 16'h1, "unmapped read valid");
        chk(d, 16'h0, "unmapped read data");
    endtask

    // every audio pattern in one write, pins and ready follow
    task automatic t_audio();
        logic [15:0] d;
        logic v;
        for (int i = 0; i < 5; i++) begin
            drv.wr(apm_pkg::AUD_PD_ADDR, drv.aud_d(i));
            cur_a = drv.aud_d(i);
            chk(outs(), exp_outs(), "audio pins");
            drv.rd(apm_pkg::AUD_PD_ADDR, d, v);
            chk({3'h0, v, d[15:8], d[3:0]},
                {4'h1, cur_a[15:8], ~cur_a[11:8]}, "audio readback");
        end
        drv.wr(apm_pkg::AUD_PD_ADDR, 16'h0000);
        cur_a = '0;
        chk(outs(), exp_outs(), "audio back to D0");
        // poll ready under a bound, as a driver would after re-enable
        for (int n = 0; n < 20 && d[3:0] !== 4'hf; n++)
            drv.rd(apm_pkg::AUD_PD_ADDR, d, v);
        chk({12'h0, d[3:0]}, 16'h000f, "sections ready again");
    endtask

    task automatic t_modem();
        logic [15:0] d;
        logic v;
        for (int i = 0; i < 4; i++) begin
            drv.wr(apm_pkg::MDM_PD_ADDR, drv.mdm_d(i));
            drv.wr(apm_pkg::MDM_LINK_ADDR, {3'h0, drv.mdm_lk(i), 12'h0});
            cur_m = drv.mdm_d(i);
            cur_lk = drv.mdm_lk(i);
            chk(outs(), exp_outs(), "modem pins");
        end
        // link-off control reads back from its own register
        drv.rd(apm_pkg::MDM_LINK_ADDR, d, v);
        chk(d, 16'h1000, "link-off readback");
        // gpio stays powered while ring wake is on, stored bit reads back
        drv.wr(apm_pkg::MDM_PD_ADDR, 16'h0f01);
        cur_m = 16'h0f01;
        chk(outs(), exp_outs(), "gpio masked by ring wake");
        drv.rd(apm_pkg::MDM_PD_ADDR, d, v);
        chk(d, 16'h0f01, "modem readback");
    endtask

    task automatic t_warm();
        logic [15:0] d;
        logic v;
        drv.wr(apm_pkg::AUD_PD_ADDR, drv.aud_d(3));
        @(posedge core_clk_i);
        #1 warm_rst_i = 1'b1;
        @(posedge core_clk_i);
        #1 warm_rst_i = 1'b0;
        cur_a = '0;
        cur_m = 16'h0001;
        cur_lk = 1'b0;
        chk(outs(), exp_outs(), "warm reset to D0");
        drv.rd(apm_pkg::MDM_PD_ADDR, d, v);
        chk(d, 16'h0001, "ring wake kept");
    endtask

    // secondary codec moves to its own clock once a modem section is down
    task automatic t_second();
        cold_rst(1'b1);
        chk(outs(), exp_outs(), "secondary in D0");
        drv.wr(apm_pkg::MDM_PD_ADDR, drv.mdm_d(1));
        cur_m = drv.mdm_d(1);
        chk(outs(), exp_outs(), "secondary own clock");
    endtask

    // hang guard, far above the fewer than one hundred cycles the run needs
    initial begin
        repeat (4000) @(posedge core_clk_i);
        error_cnt++;
        summarize();
    end

    initial begin
        warm_rst_i = 1'b0;
        cold_rst(1'b0);
        t_reset();
        t_audio();
        t_modem();
        t_warm();
        t_second();
        summarize();
    end
endmodule // testbench
